//--- rtl/zim_core.sv
// Zone flags and incremental move sequencing of a positioner axis
//
// Contract
// - Global region flag uses two global boundary settings, not the entry.
// - Entry region flag uses boundaries stored in the selected table entry.
// - Global flag in patterns 0,4,5; entry flag in 0,1,2,4,5 only.
// - Flag high while position within lower..upper inclusive, else low.
// - Start rising drops complete and raises moving, unless from standstill with the position already at the new target.
// - While start held, complete stays low even after motion ends.
// - Start from standstill to the position already reached drops complete, no moving.
// - Moving drops on arrival; complete rises in that cycle unless start still held.
// - Relative steps hitting soft limit stop there and assert complete.
// - Each entry has relative flag: 1 increment, 0 absolute.
// - Relative start from standstill: target = position plus increment.
// - Relative non-push start in ordinary move: old target plus increment.
// - Repeated relative starts in one move accumulate increments.
// - Relative non-push start in push move: push target plus increment.
// - Relative push start in a move: actual position plus increment.
`timescale 1ns/10ps
module zim_core
	import zim_pkg::*;
#(
	parameter int ENTRIES = 16,
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic start_pin,
	input wire logic [ENTRY_W-1:0] entry_sel_pin,
	input wire logic [POS_W-1:0] actual_pos,
	output logic complete_out,
	output logic moving_out,
	output logic global_region_flag,
	output logic entry_region_flag,
	output logic [POS_W-1:0] target_out,
	output logic irq
);
	logic [ENTRY_W-1:0] sel_s1_reg, sel_s2_reg;
	logic start_s1_reg, start_s2_reg, start_d_reg;
	logic [2:0] pattern_reg;
	logic [7:0] span_reg;
	logic signed [POS_W-1:0] gz_up_reg, gz_lo_reg, soft_up_reg, soft_lo_reg;
	logic [ENTRY_W-1:0] tbl_idx_reg;
	logic signed [POS_W-1:0] tbl_pos [ENTRIES];
	logic signed [POS_W-1:0] tbl_zup [ENTRIES];
	logic signed [POS_W-1:0] tbl_zlo [ENTRIES];
	logic [1:0] tbl_flg [ENTRIES];
	logic [EV_W-1:0] irq_st_reg, irq_msk_reg, ev_next;
	logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
	logic tick;
	zim_state_t state_reg;
	logic signed [POS_W-1:0] target_reg, push_tgt_reg, new_tgt;
	logic signed [POS_W:0] sum_wide;
	logic entry_push_reg, at_limit_reg;
	logic start_rise;
	logic signed [POS_W-1:0] pos_s, e_pos, e_zup, e_zlo;
	logic e_rel, e_push, arrived, in_band, gz_raw, ez_raw, gz_ok, ez_ok;
	logic acc, wr, rd;
	logic signed [POS_W-1:0] span_s;
	logic signed [POS_W:0] band_lo, band_hi;

	assign acc = psel & penable & clk_en;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign pos_s = signed'(actual_pos);

	// Pins come from the host, so two stages before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_s1_reg <= '0;
			sel_s2_reg <= '0;
			start_s1_reg <= 1'b0;
			start_s2_reg <= 1'b0;
			start_d_reg <= 1'b0;
		end else if (clk_en) begin
			sel_s1_reg <= entry_sel_pin;
			sel_s2_reg <= sel_s1_reg;
			start_s1_reg <= start_pin;
			start_s2_reg <= start_s1_reg;
			start_d_reg <= start_s2_reg;
		end
	end
	// Entry select is trusted stable by host settling time
	assign start_rise = start_s2_reg & ~start_d_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= '0;
		end else if (clk_en) begin
			if (tick)
				tick_cnt_reg <= '0;
			else
				tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end
	assign tick = (tick_cnt_reg == ($clog2(TICK_CYCLES+1))'(TICK_CYCLES-1));

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pattern_reg <= PAT_RESET;
			span_reg <= SPAN_RESET;
			gz_up_reg <= '0;
			gz_lo_reg <= '0;
			soft_up_reg <= SOFT_UP_RESET;
			soft_lo_reg <= SOFT_LO_RESET;
			tbl_idx_reg <= '0;
			irq_msk_reg <= '0;
		end else if (wr) begin
			case (paddr)
				OFF_CTRL: begin
					pattern_reg <= pwdata[CTRL_PAT_LSB +: CTRL_PAT_W];
					span_reg <= pwdata[CTRL_SPAN_LSB +: CTRL_SPAN_W];
				end
				OFF_GZ_UP: gz_up_reg <= pwdata[POS_W-1:0];
				OFF_GZ_LO: gz_lo_reg <= pwdata[POS_W-1:0];
				OFF_SOFT_UP: soft_up_reg <= pwdata[POS_W-1:0];
				OFF_SOFT_LO: soft_lo_reg <= pwdata[POS_W-1:0];
				OFF_TBL_IDX: tbl_idx_reg <= pwdata[ENTRY_W-1:0];
				OFF_IRQ_MSK: irq_msk_reg <= pwdata[EV_W-1:0];
				default: ;
			endcase
		end
	end

	// Table storage has no reset; software loads it before use
	always_ff @(posedge pclk) begin
		if (wr) begin
			case (paddr)
				OFF_TBL_POS: tbl_pos[tbl_idx_reg] <= pwdata[POS_W-1:0];
				OFF_TBL_ZUP: tbl_zup[tbl_idx_reg] <= pwdata[POS_W-1:0];
				OFF_TBL_ZLO: tbl_zlo[tbl_idx_reg] <= pwdata[POS_W-1:0];
				OFF_TBL_FLG: tbl_flg[tbl_idx_reg] <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	assign e_pos = tbl_pos[sel_s2_reg];
	assign e_rel = tbl_flg[sel_s2_reg][FLG_REL];
	assign e_push = tbl_flg[sel_s2_reg][FLG_PUSH];

	// Target arithmetic for a new start
	always_comb begin
		new_tgt = e_pos;
		sum_wide = '0;
		if (e_rel) begin
			if (e_push)
				sum_wide = pos_s + e_pos;
			else if (state_reg == ZIM_MOVE && entry_push_reg)
				sum_wide = push_tgt_reg + e_pos;
			else if (state_reg == ZIM_MOVE)
				sum_wide = target_reg + e_pos;
			else
				sum_wide = pos_s + e_pos;
			new_tgt = sum_wide[POS_W-1:0];
		end
		// Clamp to soft stroke limits
		if (new_tgt > soft_up_reg)
			new_tgt = soft_up_reg;
		else if (new_tgt < soft_lo_reg)
			new_tgt = soft_lo_reg;
	end

	// Span zero-extended and made signed, band bounds one bit wider, so negative targets and the
	// stroke ends neither flip the compare to unsigned nor wrap
	assign span_s = signed'({{(POS_W-CTRL_SPAN_W){1'b0}}, span_reg});
	assign band_lo = target_reg - span_s;
	assign band_hi = target_reg + span_s;
	assign in_band = (pos_s >= band_lo) && (pos_s <= band_hi);
	assign arrived = in_band
		|| (at_limit_reg && (pos_s >= soft_up_reg || pos_s <= soft_lo_reg));

	// Motion sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ZIM_IDLE;
			target_reg <= '0;
			push_tgt_reg <= '0;
			entry_push_reg <= 1'b0;
			at_limit_reg <= 1'b0;
			complete_out <= 1'b0;
			moving_out <= 1'b0;
		end else if (clk_en) begin
			if (start_rise) begin
				target_reg <= new_tgt;
				// Keep the push move's target for a later relative start
				entry_push_reg <= e_push;
				push_tgt_reg <= new_tgt;
				at_limit_reg <= (new_tgt == soft_up_reg)
					|| (new_tgt == soft_lo_reg);
				complete_out <= 1'b0;
				if (pos_s == new_tgt && state_reg != ZIM_MOVE) begin
					moving_out <= 1'b0;
					state_reg <= ZIM_HOLD;
				end else begin
					moving_out <= 1'b1;
					state_reg <= ZIM_MOVE;
				end
			end else begin
				case (state_reg)
					ZIM_MOVE: begin
						if (arrived) begin
							moving_out <= 1'b0;
							state_reg <= ZIM_HOLD;
							complete_out <= ~start_s2_reg;
							if (start_s2_reg)
								state_reg <= ZIM_HOLD;
						end
					end
					ZIM_HOLD: begin
						// Start still held keeps complete low
						if (!start_s2_reg && !complete_out) begin
							complete_out <= 1'b1;
							state_reg <= ZIM_IDLE;
						end
					end
					ZIM_IDLE: ;
					default: state_reg <= ZIM_IDLE;
				endcase
			end
		end
	end

	assign gz_raw = (pos_s >= gz_lo_reg) && (pos_s <= gz_up_reg);
	assign e_zup = tbl_zup[sel_s2_reg];
	assign e_zlo = tbl_zlo[sel_s2_reg];
	assign ez_raw = (pos_s >= e_zlo) && (pos_s <= e_zup);
	assign gz_ok = (pattern_reg == PAT_P0) || (pattern_reg == PAT_P4)
		|| (pattern_reg == PAT_P5);
	assign ez_ok = (pattern_reg <= PAT_P2) || (pattern_reg == PAT_P4)
		|| (pattern_reg == PAT_P5);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_region_flag <= 1'b0;
			entry_region_flag <= 1'b0;
		end else if (clk_en && tick) begin
			global_region_flag <= gz_raw & gz_ok;
			entry_region_flag <= ez_raw & ez_ok;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			target_out <= '0;
		else if (clk_en)
			target_out <= target_reg;
	end

	// Sticky events; a new event wins over a write-one clear
	always_comb begin
		ev_next = '0;
		ev_next[EV_COMPLETE] = 1'b0;
		ev_next[EV_LIMIT] = 1'b0;
		if (clk_en && state_reg == ZIM_MOVE && arrived && !start_rise) begin
			ev_next[EV_COMPLETE] = ~start_s2_reg;
			ev_next[EV_LIMIT] = at_limit_reg;
		end
		// Completion after a held start is released counts as well
		if (clk_en && state_reg == ZIM_HOLD && !start_rise && !start_s2_reg
			&& !complete_out)
			ev_next[EV_COMPLETE] = 1'b1;
		ev_next[EV_GZONE] = clk_en & tick & gz_raw & gz_ok
			& ~global_region_flag;
		ev_next[EV_EZONE] = clk_en & tick & ez_raw & ez_ok
			& ~entry_region_flag;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_st_reg <= '0;
		else if (wr && paddr == OFF_IRQ_ST)
			irq_st_reg <= (irq_st_reg & ~pwdata[EV_W-1:0]) | ev_next;
		else
			irq_st_reg <= irq_st_reg | ev_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_st_reg & irq_msk_reg);
	end

	// APB read, zero wait states; unmapped offsets answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable & clk_en;
			pslverr <= 1'b0;
			if (psel & ~penable & clk_en) begin
				prdata <= '0;
				case (paddr)
					OFF_CTRL: begin
						prdata[CTRL_PAT_LSB +: CTRL_PAT_W] <= pattern_reg;
						prdata[CTRL_SPAN_LSB +: CTRL_SPAN_W] <= span_reg;
					end
					OFF_GZ_UP: prdata[POS_W-1:0] <= gz_up_reg;
					OFF_GZ_LO: prdata[POS_W-1:0] <= gz_lo_reg;
					OFF_SOFT_UP: prdata[POS_W-1:0] <= soft_up_reg;
					OFF_SOFT_LO: prdata[POS_W-1:0] <= soft_lo_reg;
					OFF_TBL_IDX: prdata[ENTRY_W-1:0] <= tbl_idx_reg;
					OFF_TBL_POS: prdata[POS_W-1:0] <= tbl_pos[tbl_idx_reg];
					OFF_TBL_ZUP: prdata[POS_W-1:0] <= tbl_zup[tbl_idx_reg];
					OFF_TBL_ZLO: prdata[POS_W-1:0] <= tbl_zlo[tbl_idx_reg];
					OFF_TBL_FLG: prdata[1:0] <= tbl_flg[tbl_idx_reg];
					OFF_ACT_POS: prdata[POS_W-1:0] <= actual_pos;
					OFF_TARGET: prdata[POS_W-1:0] <= target_reg;
					OFF_STATUS: begin
						prdata[ST_COMPLETE] <= complete_out;
						prdata[ST_MOVING] <= moving_out;
						prdata[ST_GZONE] <= global_region_flag;
						prdata[ST_EZONE] <= entry_region_flag;
						prdata[ST_PUSHING] <= entry_push_reg;
						prdata[ST_AT_LIMIT] <= at_limit_reg;
					end
					OFF_IRQ_ST: prdata[EV_W-1:0] <= irq_st_reg;
					OFF_IRQ_MSK: prdata[EV_W-1:0] <= irq_msk_reg;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	a_start_drops_done: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && start_rise |=> !complete_out)
		else $error("complete not dropped on start");
	a_done_not_moving: assert property (@(posedge pclk) disable iff (!presetn)
		complete_out |-> !moving_out)
		else $error("moving high with complete");
	a_hold_keeps_low: assert property (@(posedge pclk) disable iff (!presetn)
		start_s2_reg && start_d_reg && !complete_out ##1 start_d_reg
		|-> !complete_out)
		else $error("complete rose while start held");
	a_gzone_pattern: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && tick && !gz_ok |=> !global_region_flag)
		else $error("global flag in wrong pattern");
	a_ezone_pattern: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && tick && !ez_ok |=> !entry_region_flag)
		else $error("entry flag in wrong pattern");
	a_gzone_range: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && tick && gz_ok && gz_raw |=> global_region_flag)
		else $error("global flag missed range");
	a_ezone_range: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && tick && ez_ok && !ez_raw |=> !entry_region_flag)
		else $error("entry flag outside range");
	a_target_limit: assert property (@(posedge pclk) disable iff (!presetn)
		target_reg <= soft_up_reg && target_reg >= soft_lo_reg)
		else $error("target beyond soft limit");
	a_same_no_move: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && start_rise && state_reg != ZIM_MOVE && pos_s == new_tgt
		|=> !moving_out)
		else $error("moving raised for same position");
	a_rel_accumulate: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && start_rise && e_rel && !e_push && state_reg == ZIM_MOVE
		&& !entry_push_reg && !(new_tgt == soft_up_reg)
		&& !(new_tgt == soft_lo_reg)
		|=> target_reg == $past(target_reg) + $past(e_pos))
		else $error("relative target not accumulated");
endmodule : zim_core

//--- rtl/zim_pkg.sv
// Package for the zone flag and incremental move block
package zim_pkg;
	localparam int POS_W = 24;
	localparam int ENTRY_W = 4;
	// APB register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_GZ_UP = 8'h04;
	localparam logic [7:0] OFF_GZ_LO = 8'h08;
	localparam logic [7:0] OFF_SOFT_UP = 8'h0C;
	localparam logic [7:0] OFF_SOFT_LO = 8'h10;
	localparam logic [7:0] OFF_TBL_IDX = 8'h14;
	localparam logic [7:0] OFF_TBL_POS = 8'h18;
	localparam logic [7:0] OFF_TBL_ZUP = 8'h1C;
	localparam logic [7:0] OFF_TBL_ZLO = 8'h20;
	localparam logic [7:0] OFF_TBL_FLG = 8'h24;
	localparam logic [7:0] OFF_ACT_POS = 8'h28;
	localparam logic [7:0] OFF_TARGET = 8'h2C;
	localparam logic [7:0] OFF_STATUS = 8'h30;
	localparam logic [7:0] OFF_IRQ_ST = 8'h34;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h38;
	// Control register fields
	localparam int CTRL_PAT_LSB = 0;
	localparam int CTRL_PAT_W = 3;
	localparam int CTRL_SPAN_LSB = 4;
	localparam int CTRL_SPAN_W = 8;
	// Table flag fields
	localparam int FLG_REL = 0;
	localparam int FLG_PUSH = 1;
	// Status bits
	localparam int ST_COMPLETE = 0;
	localparam int ST_MOVING = 1;
	localparam int ST_GZONE = 2;
	localparam int ST_EZONE = 3;
	localparam int ST_PUSHING = 4;
	localparam int ST_AT_LIMIT = 5;
	// Interrupt event bits
	localparam int EV_COMPLETE = 0;
	localparam int EV_LIMIT = 1;
	localparam int EV_GZONE = 2;
	localparam int EV_EZONE = 3;
	localparam int EV_W = 4;
	// Reset values
	localparam logic [2:0] PAT_RESET = 3'h0;
	// I/O pattern codes that decide which region flags exist
	localparam logic [2:0] PAT_P0 = 3'h0;
	localparam logic [2:0] PAT_P2 = 3'h2;
	localparam logic [2:0] PAT_P4 = 3'h4;
	localparam logic [2:0] PAT_P5 = 3'h5;
	localparam logic [7:0] SPAN_RESET = 8'h01;
	localparam logic [23:0] SOFT_UP_RESET = 24'h7FFFFF;
	localparam logic [23:0] SOFT_LO_RESET = 24'h800000;
	// Control tick, 1 ms at 100 MHz
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	// Host settling time before start
	localparam int SETTLE_MS = 6;
	typedef enum logic [1:0] {
		ZIM_IDLE = 2'b00,
		ZIM_MOVE = 2'b01,
		ZIM_HOLD = 2'b10
	} zim_state_t;
endpackage : zim_pkg

//--- verification/zim_core_tb_top.sv
// Self-checking bench for the zone flag and incremental move block
`timescale 1ns/10ps
module zim_core_tb_top;
	import zim_pkg::*;
	localparam int TK = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic start_pin, complete_out, moving_out, irq;
	logic global_region_flag, entry_region_flag;
	logic [ENTRY_W-1:0] entry_sel_pin;
	logic [POS_W-1:0] actual_pos, target_out;
	int n_mismatch, samples_checked, i;

	zim_core #(.ENTRIES(16), .TICK_CYCLES(TK)) u_zim_core (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start_pin(start_pin),
		.entry_sel_pin(entry_sel_pin), .actual_pos(actual_pos),
		.complete_out(complete_out), .moving_out(moving_out),
		.global_region_flag(global_region_flag),
		.entry_region_flag(entry_region_flag),
		.target_out(target_out), .irq(irq)
	);
	zim_plc_model #(.SETTLE_CYC(SETTLE_MS * TK)) u_zim_plc_model (
		.pclk(pclk), .complete_out(complete_out),
		.start_pin(start_pin), .entry_sel_pin(entry_sel_pin)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rd_chk

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : settle

	task automatic mv(input logic [POS_W-1:0] p);
		@(posedge pclk);
		actual_pos <= p;
	endtask : mv

	task automatic entry(input logic [31:0] n, input logic [31:0] pos,
		input logic [31:0] flg);
		wr(OFF_TBL_IDX, n);
		wr(OFF_TBL_POS, pos);
		wr(OFF_TBL_ZUP, 32'hBE);
		wr(OFF_TBL_ZLO, 32'h1D);
		wr(OFF_TBL_FLG, flg);
	endtask : entry

	// Completion must land with moving already low in the same cycle
	task automatic wait_done();
		int k;
		for (k = 0; k < 300 && complete_out !== 1'b1; k++)
			settle(1);
		if (k == 300) begin
			n_mismatch++;
			tally_and_finish();
		end
		chk(moving_out, 1'b0);
	endtask : wait_done

	task automatic zone(input logic [POS_W-1:0] p, input logic [2:0] pat,
		input logic eg, input logic ee);
		wr(OFF_CTRL, 32'h10 | pat);
		mv(p);
		settle(3 * TK);
		chk(global_region_flag, eg);
		chk(entry_region_flag, ee);
	endtask : zone

	initial begin
		presetn <= 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		actual_pos = '0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		chk(complete_out, 1'b0);
		chk(moving_out, 1'b0);
		rd_chk(OFF_CTRL, 32'h10);
		rd_chk(OFF_SOFT_UP, 32'h7FFFFF);
		rd_chk(OFF_IRQ_MSK, 32'h0);
		apb(1'b0, 8'h3C, 32'h0);
		chk(err, 1'b1);
		$display("test registers done");
		wr(OFF_GZ_UP, 32'h78);
		wr(OFF_GZ_LO, 32'h28);
		entry(32'h1, 32'h1E, 32'h0);
		entry(32'h2, 32'h0A, 32'h1);
		entry(32'h3, 32'h3C, 32'h0);
		entry(32'h4, 32'hC8, 32'h2);
		entry(32'h5, 32'h0A, 32'h3);
		u_zim_plc_model.press(4'h1, 1'b1);
		settle(1);
		chk(moving_out, 1'b1);
		chk(target_out, 32'h1E);
		mv(24'h1E);
		settle(20);
		chk(complete_out, 1'b0);
		u_zim_plc_model.release_start();
		wait_done();
		$display("test absolute move done");
		u_zim_plc_model.press(4'h2, 1'b0);
		settle(1);
		chk(target_out, 32'h28);
		u_zim_plc_model.press(4'h2, 1'b0);
		settle(1);
		chk(target_out, 32'h32);
		u_zim_plc_model.press(4'h2, 1'b0);
		settle(1);
		chk(target_out, 32'h3C);
		mv(24'h3C);
		wait_done();
		chk(entry_region_flag, 1'b1);
		u_zim_plc_model.press(4'h3, 1'b0);
		settle(1);
		chk(complete_out, 1'b0);
		chk(moving_out, 1'b0);
		wait_done();
		$display("test relative moves done");
		wr(OFF_SOFT_UP, 32'h41);
		u_zim_plc_model.press(4'h2, 1'b0);
		settle(1);
		chk(target_out, 32'h41);
		mv(24'h41);
		wait_done();
		wr(OFF_SOFT_UP, 32'h7FFFFF);
		u_zim_plc_model.press(4'h4, 1'b0);
		settle(1);
		chk(target_out, 32'hC8);
		u_zim_plc_model.press(4'h2, 1'b0);
		settle(1);
		chk(target_out, 32'hD2);
		rd_chk(OFF_STATUS, 32'h0E);
		mv(24'hD2);
		wait_done();
		$display("test limit and push done");
		apb(1'b0, OFF_IRQ_ST, 32'h0);
		chk(rd[EV_COMPLETE], 1'b1);
		wr(OFF_IRQ_MSK, 32'h1);
		settle(2);
		chk(irq, 1'b1);
		wr(OFF_IRQ_ST, 32'h1);
		settle(2);
		chk(irq, 1'b0);
		$display("test interrupt done");
		u_zim_plc_model.press(4'h1, 1'b0);
		u_zim_plc_model.press(4'h5, 1'b0);
		settle(1);
		chk(target_out, 32'hDC);
		for (i = 0; i < 6; i++)
			zone(24'h3C, i[2:0], i == 0 || i == 4 || i == 5, i != 3);
		zone(24'h28, 3'h0, 1'b1, 1'b1);
		zone(24'h78, 3'h0, 1'b1, 1'b1);
		zone(24'h27, 3'h0, 1'b0, 1'b1);
		zone(24'h79, 3'h0, 1'b0, 1'b1);
		zone(24'h1C, 3'h0, 1'b0, 1'b0);
		zone(24'hC8, 3'h0, 1'b0, 1'b0);
		$display("test zones done");
		chk(u_zim_plc_model.n_timeout, 32'h0);
		tally_and_finish();
	end
endmodule : zim_core_tb_top

//--- verification/zim_plc_model.sv
// Host controller model driving the entry select and start pins
`timescale 1ns/10ps
module zim_plc_model
	import zim_pkg::*;
#(
	parameter int SETTLE_CYC = 60
) (
	input wire logic pclk,
	input wire logic complete_out,
	output logic start_pin,
	output logic [ENTRY_W-1:0] entry_sel_pin
);
	int n_timeout;
	initial begin
		start_pin = 1'b0;
		entry_sel_pin = '0;
		n_timeout = 0;
	end
	task automatic press(input logic [ENTRY_W-1:0] n, input bit hold);
		int i;
		@(posedge pclk);
		entry_sel_pin <= n;
		repeat (SETTLE_CYC) @(posedge pclk);
		start_pin <= 1'b1;
		// A few scans pass before the host looks back at its inputs
		repeat (4) @(posedge pclk);
		for (i = 0; i < 50 && complete_out !== 1'b0; i++) begin
			@(posedge pclk);
		end
		if (i == 50) begin
			n_timeout++;
			zim_core_tb_top.n_mismatch++;
			zim_core_tb_top.tally_and_finish();
		end
		if (!hold)
			start_pin <= 1'b0;
	endtask : press
	task automatic release_start();
		@(posedge pclk);
		start_pin <= 1'b0;
	endtask : release_start
endmodule : zim_plc_model
